// *** hw/sgram_pkg.sv ***
// Shared constants, command codes and types for the graphics DRAM host.
package sgram_pkg;

	localparam int NUM_BANKS = 2;
	localparam int ROW_W     = 9;
	localparam int COL_W     = 8;
	localparam int DATA_W    = 32;
	localparam int MASK_W    = 4;
	localparam int GAP_W     = 3;
	localparam int PIPE_W    = 4;
	localparam int AP_BIT    = 8;

	// Clock rate and refresh interval; the cycle count rounds down.
	localparam int CLK_PERIOD_NS    = 20;
	localparam int REF_INTERVAL_NS  = 15600;
	localparam int REF_INTERVAL_CYC = REF_INTERVAL_NS / CLK_PERIOD_NS;
	localparam int REF_CNT_W        = 10;

	// Minimum command spacings in clock cycles, faster and slower grades.
	localparam logic [GAP_W-1:0] ACT_OTHER_BANK_GAP  = 3'h2;
	localparam logic [GAP_W-1:0] COLUMN_CMD_GAP      = 3'h1;
	localparam logic [GAP_W-1:0] ACT_COL_GAP_FAST    = 3'h3;
	localparam logic [GAP_W-1:0] ACT_COL_GAP_SLOW    = 3'h2;
	localparam logic [GAP_W-1:0] PRE_ACT_GAP_FAST    = 3'h3;
	localparam logic [GAP_W-1:0] PRE_ACT_GAP_SLOW    = 3'h2;
	localparam logic [GAP_W-1:0] ACT_PRE_GAP_FAST    = 3'h4;
	localparam logic [GAP_W-1:0] ACT_PRE_GAP_SLOW    = 3'h3;
	localparam logic [GAP_W-1:0] ACT_ACT_GAP_FAST    = 3'h7;
	localparam logic [GAP_W-1:0] ACT_ACT_GAP_SLOW    = 3'h5;
	localparam logic [GAP_W-1:0] BLK_PRE_GAP_FAST    = 3'h3;
	localparam logic [GAP_W-1:0] BLK_PRE_GAP_SLOW    = 3'h2;
	localparam logic [GAP_W-1:0] BLOCK_WRITE_CYC_GAP = 3'h2;
	localparam logic [GAP_W-1:0] WR_REC_GAP_FAST     = 3'h2;
	localparam logic [GAP_W-1:0] WR_REC_GAP_SLOW     = 3'h1;
	localparam logic [GAP_W-1:0] REG_LOAD_CMD_GAP    = 3'h2;

	// Read latency in clocks per grade.
	localparam logic [1:0] CL_FAST = 2'h3;
	localparam logic [1:0] CL_SLOW = 2'h2;

	// Command codes as {cs_b, ras_b, cas_b, we_b, dsf}.
	localparam logic [4:0] CMD_MODE_LOAD    = 5'h00;
	localparam logic [4:0] CMD_SPECIAL_LOAD = 5'h01;
	localparam logic [4:0] CMD_REFRESH      = 5'h02;
	localparam logic [4:0] CMD_ACTIVATE     = 5'h06;
	localparam logic [4:0] CMD_WRITE        = 5'h08;
	localparam logic [4:0] CMD_BLOCK_WRITE  = 5'h09;
	localparam logic [4:0] CMD_READ         = 5'h0a;
	localparam logic [4:0] CMD_PRECHARGE    = 5'h04;
	localparam logic [4:0] CMD_NOP          = 5'h0e;

	typedef enum logic [2:0] {
		OP_READ         = 3'h0,
		OP_WRITE        = 3'h1,
		OP_BLOCK_WRITE  = 3'h2,
		OP_MODE_LOAD    = 3'h3,
		OP_SPECIAL_LOAD = 3'h4
	} op_e;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'h1,
		ST_BUSY    = 3'h2,
		ST_REFRESH = 3'h4
	} state_e;

endpackage

// *** hw/gap_counter.sv ***
// Down counter that keeps the longest outstanding command spacing.
`timescale 1ns/10ps
module gap_counter
	import sgram_pkg::*;
(
	input  wire logic             ref_clk_i,
	input  wire logic             rst_b_i,
	input  wire logic             load_i,
	input  wire logic [GAP_W-1:0] gap_i,
	output logic                  ok_o
);

	logic [GAP_W-1:0] cnt_q;
	logic [GAP_W-1:0] cnt_d;
	logic [GAP_W-1:0] dec;
	logic [GAP_W-1:0] need;

	// A spacing of N issues the next command N edges later, so N-1 loads.
	always_comb begin
		dec   = (cnt_q == '0) ? '0 : cnt_q - 3'h1;
		need  = gap_i - 3'h1;
		cnt_d = (load_i && need > dec) ? need : dec;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign ok_o = (cnt_q == '0);

endmodule

// *** hw/refresh_ticker.sv ***
// Free running divider that requests one refresh per interval.
`timescale 1ns/10ps
module refresh_ticker
	import sgram_pkg::*;
(
	input  wire logic ref_clk_i,
	input  wire logic rst_b_i,
	output logic      tick_o
);

	localparam logic [REF_CNT_W-1:0] LAST = REF_CNT_W'(REF_INTERVAL_CYC - 1);

	logic [REF_CNT_W-1:0] cnt_q;
	logic [REF_CNT_W-1:0] cnt_d;
	logic                 tick_q;
	logic                 tick_d;

	always_comb begin
		tick_d = (cnt_q == LAST);
		cnt_d  = tick_d ? '0 : cnt_q + 10'h001;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick_o = tick_q;

endmodule

// *** hw/sgram_host_ctrl.sv ***
// Host controller that drives a two-bank graphics DRAM within its spacings.
//
// Overview of operation
// - Two clocks between activates to different banks.
// - Column commands may follow each other every clock.
// - Activate to column waits three, slow two.
// - Precharge to activate waits three, slow two.
// - Activate to precharge waits four, slow three.
// - Same-bank activates, refreshes: seven, slow five.
// - Block write to precharge three, slow two.
// - Block writes at least two clocks apart.
// - Write data to precharge two, slow one.
// - Register load, then two clocks before next.
// - Activate carries bank and nine-bit row.
// - Column carries bank, column; bit 8 autoprecharge.
`timescale 1ns/10ps
module sgram_host_ctrl
	import sgram_pkg::*;
(
	input  wire logic              ref_clk_i,
	input  wire logic              rst_b_i,
	input  wire logic              slow_grade_i,
	input  wire logic              req_valid_i,
	input  wire op_e               req_op_i,
	input  wire logic              req_bank_i,
	input  wire logic [ROW_W-1:0]  req_row_i,
	input  wire logic [COL_W-1:0]  req_col_i,
	input  wire logic              req_auto_pre_i,
	input  wire logic [DATA_W-1:0] req_wdata_i,
	input  wire logic [MASK_W-1:0] req_wmask_i,
	output logic                   req_ready_o,
	output logic                   req_done_o,
	output logic [DATA_W-1:0]      rd_data_o,
	output logic                   rd_valid_o,
	output logic                   cs_b_o,
	output logic                   ras_b_o,
	output logic                   cas_b_o,
	output logic                   we_b_o,
	output logic                   dsf_o,
	output logic                   ba_o,
	output logic [ROW_W-1:0]       addr_o,
	output logic [MASK_W-1:0]      dqm_o,
	output logic [DATA_W-1:0]      dq_o,
	output logic                   dq_oe_o,
	input  wire logic [DATA_W-1:0] dq_i
);

	state_e                       state_q, state_d;
	logic [4:0]                   cmd_q, cmd_d;
	logic                         ba_q, ba_d;
	logic [ROW_W-1:0]             addr_q, addr_d;
	logic [MASK_W-1:0]            dqm_q, dqm_d;
	logic [DATA_W-1:0]            dq_q, dq_d;
	logic                         dq_oe_q, dq_oe_d;
	logic                         ready_q, ready_d;
	logic                         done_q, done_d;
	logic                         ref_pend_q, ref_pend_d;
	logic [NUM_BANKS-1:0]         open_q, open_d;
	logic [ROW_W-1:0]             row_q [NUM_BANKS];
	logic [ROW_W-1:0]             row_d [NUM_BANKS];
	op_e                          op_q, op_d;
	logic                         bank_q, bank_d;
	logic [ROW_W-1:0]             rrow_q, rrow_d;
	logic [COL_W-1:0]             col_q, col_d;
	logic                         ap_q, ap_d;
	logic [DATA_W-1:0]            wdata_q, wdata_d;
	logic [MASK_W-1:0]            wmask_q, wmask_d;
	logic [PIPE_W-1:0]            rd_pipe_q, rd_pipe_d;
	logic [DATA_W-1:0]            rd_data_q, rd_data_d;
	logic                         rd_valid_q, rd_valid_d;
	logic                         ref_tick;
	logic                         want_pre_all;
	logic [NUM_BANKS-1:0]         col_ok, pre_ok, act_ok;
	logic [NUM_BANKS-1:0]         col_ld, pre_ld, act_ld;
	logic [GAP_W-1:0]             col_gap [NUM_BANKS];
	logic [GAP_W-1:0]             pre_gap [NUM_BANKS];
	logic [GAP_W-1:0]             act_gap [NUM_BANKS];
	logic                         rrd_ok, bwc_ok, lrc_ok;
	logic                         rrd_ld, bwc_ld, lrc_ld;
	logic [GAP_W-1:0]             act_to_column_gap;
	logic [GAP_W-1:0]             precharge_to_act_gap;
	logic [GAP_W-1:0]             act_to_precharge_gap;
	logic [GAP_W-1:0]             act_to_act_same_bank_gap;
	logic [GAP_W-1:0]             block_write_to_precharge_gap;
	logic [GAP_W-1:0]             write_recovery_gap;
	logic [1:0]                   cas_latency;

	always_comb begin
		act_to_column_gap  = slow_grade_i ? ACT_COL_GAP_SLOW
		                                  : ACT_COL_GAP_FAST;
		precharge_to_act_gap = slow_grade_i ? PRE_ACT_GAP_SLOW
		                                    : PRE_ACT_GAP_FAST;
		act_to_precharge_gap = slow_grade_i ? ACT_PRE_GAP_SLOW
		                                    : ACT_PRE_GAP_FAST;
		act_to_act_same_bank_gap = slow_grade_i ? ACT_ACT_GAP_SLOW
		                                        : ACT_ACT_GAP_FAST;
		block_write_to_precharge_gap = slow_grade_i ? BLK_PRE_GAP_SLOW
		                                            : BLK_PRE_GAP_FAST;
		write_recovery_gap = slow_grade_i ? WR_REC_GAP_SLOW
		                                  : WR_REC_GAP_FAST;
		cas_latency = slow_grade_i ? CL_SLOW : CL_FAST;
	end

	genvar b;
	generate
		for (b = 0; b < NUM_BANKS; b++) begin : g_bank
			gap_counter u_col (
				.ref_clk_i (ref_clk_i),
				.rst_b_i   (rst_b_i),
				.load_i    (col_ld[b]),
				.gap_i     (col_gap[b]),
				.ok_o      (col_ok[b])
			);
			gap_counter u_pre (
				.ref_clk_i (ref_clk_i),
				.rst_b_i   (rst_b_i),
				.load_i    (pre_ld[b]),
				.gap_i     (pre_gap[b]),
				.ok_o      (pre_ok[b])
			);
			gap_counter u_act (
				.ref_clk_i (ref_clk_i),
				.rst_b_i   (rst_b_i),
				.load_i    (act_ld[b]),
				.gap_i     (act_gap[b]),
				.ok_o      (act_ok[b])
			);
		end
	endgenerate

	gap_counter u_rrd (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.load_i    (rrd_ld),
		.gap_i     (ACT_OTHER_BANK_GAP),
		.ok_o      (rrd_ok)
	);
	gap_counter u_bwc (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.load_i    (bwc_ld),
		.gap_i     (BLOCK_WRITE_CYC_GAP),
		.ok_o      (bwc_ok)
	);
	gap_counter u_lrc (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.load_i    (lrc_ld),
		.gap_i     (REG_LOAD_CMD_GAP),
		.ok_o      (lrc_ok)
	);

	refresh_ticker u_ref (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.tick_o    (ref_tick)
	);

	// column command spacing
	// Column spacing is one clock, so back to back column commands need
	// no counter of their own; COLUMN_CMD_GAP documents that figure.
	always_comb begin
		state_d = state_q;
		cmd_d = CMD_NOP;
		ba_d = ba_q;
		addr_d = addr_q;
		dqm_d = '0;
		dq_d = dq_q;
		dq_oe_d = 1'b0;
		done_d = 1'b0;
		ref_pend_d = ref_pend_q;
		open_d = open_q;
		row_d = row_q;
		op_d = op_q;
		bank_d = bank_q;
		rrow_d = rrow_q;
		col_d = col_q;
		ap_d = ap_q;
		wdata_d = wdata_q;
		wmask_d = wmask_q;
		want_pre_all = 1'b0;
		col_ld = '0;
		pre_ld = '0;
		act_ld = '0;
		rrd_ld = 1'b0;
		bwc_ld = 1'b0;
		lrc_ld = 1'b0;
		for (int i = 0; i < NUM_BANKS; i++) begin
			col_gap[i] = act_to_column_gap;
			pre_gap[i] = act_to_precharge_gap;
			act_gap[i] = act_to_act_same_bank_gap;
		end
		rd_pipe_d = {rd_pipe_q[PIPE_W-2:0], 1'b0};
		case (state_q)
			ST_IDLE: begin
				if (req_valid_i && ready_q) begin
					op_d = req_op_i;
					bank_d = req_bank_i;
					rrow_d = req_row_i;
					col_d = req_col_i;
					ap_d = req_auto_pre_i;
					wdata_d = req_wdata_i;
					wmask_d = req_wmask_i;
					state_d = ST_BUSY;
				end else if (ref_pend_q) begin
					state_d = ST_REFRESH;
				end
			end
			ST_BUSY: begin
				if (op_q == OP_MODE_LOAD || op_q == OP_SPECIAL_LOAD) begin
					if (|open_q) begin
						want_pre_all = 1'b1;
					end else if ((&act_ok) && lrc_ok) begin
						cmd_d = (op_q == OP_MODE_LOAD) ? CMD_MODE_LOAD
						                               : CMD_SPECIAL_LOAD;
						ba_d = bank_q;
						addr_d = rrow_q;
						dq_d = wdata_q;
						dq_oe_d = (op_q == OP_SPECIAL_LOAD);
						lrc_ld = 1'b1;
						done_d = 1'b1;
						state_d = ST_IDLE;
					end
				end else if (open_q[bank_q] && row_q[bank_q] == rrow_q) begin
					if (col_ok[bank_q] && lrc_ok &&
					    (op_q != OP_BLOCK_WRITE || bwc_ok) &&
					    (!ap_q || pre_ok[bank_q])) begin
						ba_d = bank_q;
						addr_d = {ap_q, col_q};
						done_d = 1'b1;
						state_d = ST_IDLE;
						if (op_q == OP_READ) begin
							cmd_d = CMD_READ;
							rd_pipe_d[0] = 1'b1;
						end else begin
							cmd_d = (op_q == OP_WRITE) ? CMD_WRITE
							                           : CMD_BLOCK_WRITE;
							dq_d = wdata_q;
							dq_oe_d = 1'b1;
							dqm_d = wmask_q;
							pre_ld[bank_q] = 1'b1;
							pre_gap[bank_q] = (op_q == OP_WRITE) ?
							    write_recovery_gap :
							    block_write_to_precharge_gap;
							bwc_ld = (op_q == OP_BLOCK_WRITE);
						end
						if (ap_q) begin
							// Internal precharge time is unknown, so wait
							// out recovery plus precharge before reopening.
							open_d[bank_q] = 1'b0;
							act_ld[bank_q] = 1'b1;
							act_gap[bank_q] = GAP_W'(pre_gap[bank_q] +
							                         precharge_to_act_gap);
						end
					end
				end else if (open_q[bank_q]) begin
					// single bank precharge on row miss
					if (pre_ok[bank_q] && lrc_ok) begin
						cmd_d = CMD_PRECHARGE;
						ba_d = bank_q;
						addr_d = '0;
						open_d[bank_q] = 1'b0;
						act_ld[bank_q] = 1'b1;
						act_gap[bank_q] = precharge_to_act_gap;
					end
				end else if (act_ok[bank_q] && rrd_ok && lrc_ok) begin
					cmd_d = CMD_ACTIVATE;
					ba_d = bank_q;
					addr_d = rrow_q;
					open_d[bank_q] = 1'b1;
					row_d[bank_q] = rrow_q;
					col_ld[bank_q] = 1'b1;
					pre_ld[bank_q] = 1'b1;
					act_ld[bank_q] = 1'b1;
					rrd_ld = 1'b1;
				end
			end
			ST_REFRESH: begin
				if (|open_q) begin
					want_pre_all = 1'b1;
				end else if ((&act_ok) && lrc_ok) begin
					cmd_d = CMD_REFRESH;
					act_ld = '1;
					ref_pend_d = 1'b0;
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if (want_pre_all && (&pre_ok) && lrc_ok) begin
			cmd_d = CMD_PRECHARGE;
			addr_d = ROW_W'(1) << AP_BIT;
			open_d = '0;
			for (int i = 0; i < NUM_BANKS; i++) begin
				act_ld[i] = 1'b1;
				act_gap[i] = precharge_to_act_gap;
			end
		end
		// A new interval beats a refresh issued in the same cycle.
		if (ref_tick) begin
			ref_pend_d = 1'b1;
		end
		ready_d = (state_d == ST_IDLE) && !ref_pend_d;
		rd_valid_d = rd_pipe_q[cas_latency];
		rd_data_d = rd_valid_d ? dq_i : rd_data_q;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			state_q <= ST_IDLE;
			cmd_q <= CMD_NOP;
			ba_q <= 1'b0;
			addr_q <= '0;
			dqm_q <= '0;
			dq_q <= '0;
			dq_oe_q <= 1'b0;
			ready_q <= 1'b0;
			done_q <= 1'b0;
			ref_pend_q <= 1'b0;
			open_q <= '0;
			row_q <= '{default: '0};
			op_q <= OP_READ;
			bank_q <= 1'b0;
			rrow_q <= '0;
			col_q <= '0;
			ap_q <= 1'b0;
			wdata_q <= '0;
			wmask_q <= '0;
			rd_pipe_q <= '0;
			rd_data_q <= '0;
			rd_valid_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cmd_q <= cmd_d;
			ba_q <= ba_d;
			addr_q <= addr_d;
			dqm_q <= dqm_d;
			dq_q <= dq_d;
			dq_oe_q <= dq_oe_d;
			ready_q <= ready_d;
			done_q <= done_d;
			ref_pend_q <= ref_pend_d;
			open_q <= open_d;
			row_q <= row_d;
			op_q <= op_d;
			bank_q <= bank_d;
			rrow_q <= rrow_d;
			col_q <= col_d;
			ap_q <= ap_d;
			wdata_q <= wdata_d;
			wmask_q <= wmask_d;
			rd_pipe_q <= rd_pipe_d;
			rd_data_q <= rd_data_d;
			rd_valid_q <= rd_valid_d;
		end
	end

	assign {cs_b_o, ras_b_o, cas_b_o, we_b_o, dsf_o} = cmd_q;
	assign ba_o = ba_q;
	assign addr_o = addr_q;
	assign dqm_o = dqm_q;
	assign dq_o = dq_q;
	assign dq_oe_o = dq_oe_q;
	assign req_ready_o = ready_q;
	assign req_done_o = done_q;
	assign rd_data_o = rd_data_q;
	assign rd_valid_o = rd_valid_q;

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	logic is_act, is_blk, is_load, is_ref, is_pre;
	assign is_act = (cmd_q == CMD_ACTIVATE);
	assign is_blk = (cmd_q == CMD_BLOCK_WRITE);
	assign is_ref = (cmd_q == CMD_REFRESH);
	assign is_pre = (cmd_q == CMD_PRECHARGE);
	assign is_load = (cmd_q == CMD_MODE_LOAD) ||
	                 (cmd_q == CMD_SPECIAL_LOAD);

	sequence s_ref_quiet;
		(!is_ref)[*4] ##1 (slow_grade_i || !is_ref)[*2];
	endsequence

	act_other_gap_a: assert property (is_act |=> !is_act)
		else $error("activates issued on adjacent clocks");
	blk_cycle_gap_a: assert property (is_blk |=> !is_blk)
		else $error("block writes issued on adjacent clocks");
	load_cmd_gap_a: assert property (is_load |=> cmd_q == CMD_NOP)
		else $error("command too soon after register load");
	ref_closed_a: assert property (is_ref |-> open_q == '0)
		else $error("refresh issued with a bank open");
	ref_cycle_gap_a: assert property (is_ref |=> s_ref_quiet)
		else $error("refreshes spaced too closely");

	generate
		for (b = 0; b < NUM_BANKS; b++) begin : g_chk
			logic act_b, pre_b, pre1_b, col_b, blk_b, wr_b;
			assign act_b = is_act && ba_q == 1'(b);
			assign pre_b = is_pre && (addr_q[AP_BIT] || ba_q == 1'(b));
			assign pre1_b = is_pre && !addr_q[AP_BIT] && ba_q == 1'(b);
			assign col_b = ba_q == 1'(b) && (cmd_q == CMD_READ ||
			               cmd_q == CMD_WRITE || is_blk);
			assign blk_b = is_blk && ba_q == 1'(b);
			assign wr_b = cmd_q == CMD_WRITE && ba_q == 1'(b);

			sequence s_no_pre_ras;
				(!pre_b)[*2] ##1 (slow_grade_i || !pre_b);
			endsequence
			sequence s_no_act_rc;
				(!act_b)[*4] ##1 (slow_grade_i || !act_b)[*2];
			endsequence

			act_col_gap_a: assert property (
				act_b |=> !col_b ##1 (slow_grade_i || !col_b))
				else $error("column command too soon after activate");
			pre_act_gap_a: assert property (
				pre1_b |=> !act_b ##1 (slow_grade_i || !act_b))
				else $error("activate too soon after precharge");
			act_pre_gap_a: assert property (act_b |=> s_no_pre_ras)
				else $error("precharge too soon after activate");
			act_same_gap_a: assert property (act_b |=> s_no_act_rc)
				else $error("same bank activates too close");
			blk_pre_gap_a: assert property (
				blk_b |=> !pre_b ##1 (slow_grade_i || !pre_b))
				else $error("precharge too soon after block write");
			wr_pre_gap_a: assert property (
				wr_b && !slow_grade_i |=> !pre_b)
				else $error("precharge too soon after write data");
		end
	endgenerate

endmodule

// *** verif/sgram_dev_model.sv ***
// Behavioural two-bank graphics DRAM that counts command spacing faults.
`timescale 1ns/10ps
module sgram_dev_model
	import sgram_pkg::*;
(
	input  wire logic              ref_clk_i,
	input  wire logic              slow_i,
	input  wire logic [4:0]        cmd_i,
	input  wire logic              ba_i,
	input  wire logic [ROW_W-1:0]  addr_i,
	input  wire logic [MASK_W-1:0] dqm_i,
	input  wire logic [DATA_W-1:0] dq_i,
	input  wire logic              dq_oe_i,
	output logic [DATA_W-1:0]      dq_o,
	output logic [7:0]             viol_o,
	output logic [7:0]             ref_o
);
	int                cyc, t_bw, t_load, t_ref;
	int                t_act[2], t_pre[2], t_blk[2], t_wr[2];
	logic              open_q[2];
	logic [ROW_W-1:0]  row_q[2];
	logic [DATA_W-1:0] mem[logic [17:0]];
	logic [DATA_W-1:0] w;
	logic [17:0]       k;
	logic              b;
	int                rd_t[$];
	logic [DATA_W-1:0] rd_d[$];

	function automatic int gp(input logic [GAP_W-1:0] f,
		input logic [GAP_W-1:0] s);
		return slow_i ? int'(s) : int'(f);
	endfunction

	task automatic need(input logic ok);
		if (ok !== 1'b1)
			viol_o = viol_o + 8'h01;
	endtask

	task automatic close_bank(input logic bk, input int t);
		if (open_q[bk]) begin
			need(t - t_act[bk] >= gp(ACT_PRE_GAP_FAST, ACT_PRE_GAP_SLOW));
			need(t - t_blk[bk] >= gp(BLK_PRE_GAP_FAST, BLK_PRE_GAP_SLOW));
			need(t - t_wr[bk] >= gp(WR_REC_GAP_FAST, WR_REC_GAP_SLOW));
			open_q[bk] = 1'b0;
			t_pre[bk] = t;
		end
	endtask

	initial begin
		viol_o = 8'h00;
		ref_o = 8'h00;
		dq_o = '0;
		cyc = 0;
		t_bw = -100;
		t_load = -100;
		t_ref = -100;
		t_act = '{-100, -100};
		t_pre = '{-100, -100};
		t_blk = '{-100, -100};
		t_wr = '{-100, -100};
		open_q = '{1'b0, 1'b0};
	end

	always @(posedge ref_clk_i) begin
		cyc = cyc + 1;
		b = ba_i;
		if (!cmd_i[4] && cmd_i[4:1] != 4'h7)
			need(cyc - t_load >= REG_LOAD_CMD_GAP);
		case (cmd_i)
			CMD_ACTIVATE: begin
				need(!open_q[b] && cyc - t_act[!b] >= ACT_OTHER_BANK_GAP);
				need(cyc - t_pre[b] >= gp(PRE_ACT_GAP_FAST, PRE_ACT_GAP_SLOW));
				need(cyc - t_act[b] >= gp(ACT_ACT_GAP_FAST, ACT_ACT_GAP_SLOW));
				t_act[b] = cyc;
				open_q[b] = 1'b1;
				row_q[b] = addr_i;
			end
			CMD_READ, CMD_WRITE, CMD_BLOCK_WRITE: begin
				need(open_q[b]);
				need(cyc - t_act[b] >= gp(ACT_COL_GAP_FAST, ACT_COL_GAP_SLOW));
				k = {b, row_q[b], addr_i[COL_W-1:0]};
				w = mem.exists(k) ? mem[k] : '0;
				if (cmd_i == CMD_READ) begin
					rd_t.push_back(cyc + gp({1'b0, CL_FAST}, {1'b0, CL_SLOW}) - 1);
					rd_d.push_back(w);
				end else begin
					// Block fill is kept as a plain write of the data word.
					need(dq_oe_i);
					for (int i = 0; i < MASK_W; i++)
						if (!dqm_i[i])
							w[8*i+:8] = dq_i[8*i+:8];
					mem[k] = w;
				end
				if (cmd_i == CMD_WRITE)
					t_wr[b] = cyc;
				if (cmd_i == CMD_BLOCK_WRITE) begin
					need(cyc - t_bw >= BLOCK_WRITE_CYC_GAP);
					t_bw = cyc;
					t_blk[b] = cyc;
				end
				if (addr_i[AP_BIT])
					close_bank(b, cyc + (cmd_i == CMD_BLOCK_WRITE ?
						gp(BLK_PRE_GAP_FAST, BLK_PRE_GAP_SLOW) :
						gp(WR_REC_GAP_FAST, WR_REC_GAP_SLOW)));
			end
			CMD_PRECHARGE: begin
				if (addr_i[AP_BIT] || !b)
					close_bank(1'b0, cyc);
				if (addr_i[AP_BIT] || b)
					close_bank(1'b1, cyc);
			end
			CMD_REFRESH: begin
				need(!open_q[0] && !open_q[1]);
				need(cyc - t_ref >= gp(ACT_ACT_GAP_FAST, ACT_ACT_GAP_SLOW));
				t_ref = cyc;
				ref_o = ref_o + 8'h01;
			end
			CMD_MODE_LOAD, CMD_SPECIAL_LOAD: t_load = cyc;
			default: ;
		endcase
		// Idle data lines toggle so a stale capture cannot match.
		if (rd_t.size() > 0 && rd_t[0] == cyc) begin
			dq_o <= rd_d.pop_front();
			rd_t.delete(0);
		end else
			dq_o <= ~dq_o;
	end
endmodule

// *** verif/test_sgram_host_ctrl.sv ***
// Self-checking bench for the graphics DRAM host controller.
`timescale 1ns/10ps
module test_sgram_host_ctrl
	import sgram_pkg::*;
;
	logic              clk, rst_b, slow, valid, bank, ap;
	logic              ready, done, rd_v, cs_b, ras_b, cas_b, we_b;
	logic              dsf, ba, dq_oe;
	op_e               op;
	logic [ROW_W-1:0]  row, addr;
	logic [COL_W-1:0]  col;
	logic [DATA_W-1:0] wdata, rd_data, dq_o, dq_i, got;
	logic [MASK_W-1:0] wmask, dqm;
	logic [7:0]        viol, refs, r0;
	int                err_count, n_compared;

	sgram_host_ctrl uut (.ref_clk_i(clk), .rst_b_i(rst_b),
		.slow_grade_i(slow), .req_valid_i(valid), .req_op_i(op),
		.req_bank_i(bank), .req_row_i(row), .req_col_i(col),
		.req_auto_pre_i(ap), .req_wdata_i(wdata), .req_wmask_i(wmask),
		.req_ready_o(ready), .req_done_o(done), .rd_data_o(rd_data),
		.rd_valid_o(rd_v), .cs_b_o(cs_b), .ras_b_o(ras_b),
		.cas_b_o(cas_b), .we_b_o(we_b), .dsf_o(dsf), .ba_o(ba),
		.addr_o(addr), .dqm_o(dqm), .dq_o(dq_o), .dq_oe_o(dq_oe),
		.dq_i(dq_i));

	sgram_dev_model dev (.ref_clk_i(clk), .slow_i(slow),
		.cmd_i({cs_b, ras_b, cas_b, we_b, dsf}), .ba_i(ba),
		.addr_i(addr), .dqm_i(dqm), .dq_i(dq_o), .dq_oe_i(dq_oe),
		.dq_o(dq_i), .viol_o(viol), .ref_o(refs));

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] seen);
		n_compared++;
		if (seen !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
			err_count++;
		end
	endtask

	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic req(input op_e o, input logic bk, input logic [8:0] r,
		input logic [7:0] c, input logic a, input logic [31:0] wd,
		input logic [3:0] wm);
		int n;
		@(posedge clk);
		valid <= 1'b1;
		op <= o;
		bank <= bk;
		row <= r;
		col <= c;
		ap <= a;
		wdata <= wd;
		wmask <= wm;
		n = 0;
		@(negedge clk);
		while (ready !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		valid <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (done !== 1'b1 && n < 100);
		chk("request done", 32'h1, {31'h0, done});
		if (o == OP_READ) begin
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while (rd_v !== 1'b1 && n < 10);
			chk("read latency", slow ? 32'h3 : 32'h4, n);
			got = rd_data;
		end
	endtask

	task automatic rdchk(input logic bk, input logic [8:0] r,
		input logic [7:0] c, input logic a, input logic [31:0] exp);
		req(OP_READ, bk, r, c, a, 32'h0, 4'h0);
		chk("read data", exp, got);
	endtask

	task automatic end_test(input string name);
		chk("spacing faults", 32'h0, {24'h0, viol});
		$display("test %s finished", name);
	endtask

	task automatic do_reset(input logic s);
		rst_b <= 1'b0;
		slow <= s;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
	endtask

	task automatic t_rw();
		req(OP_WRITE, 1'b0, 9'h105, 8'h03, 1'b0, 32'h1234_5678, 4'h0);
		rdchk(1'b0, 9'h105, 8'h03, 1'b0, 32'h1234_5678);
		req(OP_WRITE, 1'b0, 9'h105, 8'h03, 1'b0, 32'hcafe_0000, 4'h3);
		rdchk(1'b0, 9'h105, 8'h03, 1'b0, 32'hcafe_5678);
		end_test("write_read");
	endtask

	task automatic t_miss();
		req(OP_WRITE, 1'b0, 9'h0a6, 8'hff, 1'b0, 32'h0bad_f00d, 4'h0);
		rdchk(1'b0, 9'h105, 8'h03, 1'b0, 32'hcafe_5678);
		rdchk(1'b0, 9'h0a6, 8'hff, 1'b0, 32'h0bad_f00d);
		req(OP_WRITE, 1'b1, 9'h105, 8'h03, 1'b0, 32'h00c0_ffee, 4'h0);
		rdchk(1'b1, 9'h105, 8'h03, 1'b0, 32'h00c0_ffee);
		end_test("row_miss");
	endtask

	task automatic t_blk();
		req(OP_BLOCK_WRITE, 1'b1, 9'h0f0, 8'h08, 1'b0, 32'h0f, 4'h0);
		req(OP_BLOCK_WRITE, 1'b1, 9'h0f0, 8'h10, 1'b0, 32'hf0, 4'h0);
		rdchk(1'b1, 9'h105, 8'h03, 1'b0, 32'h00c0_ffee);
		rdchk(1'b1, 9'h0f0, 8'h10, 1'b0, 32'h0000_00f0);
		end_test("block_write");
	endtask

	task automatic t_ap();
		req(OP_WRITE, 1'b0, 9'h1ff, 8'h01, 1'b1, 32'h5555_aaaa, 4'h0);
		rdchk(1'b0, 9'h1ff, 8'h01, 1'b1, 32'h5555_aaaa);
		rdchk(1'b0, 9'h0a6, 8'hff, 1'b0, 32'h0bad_f00d);
		end_test("auto_precharge");
	endtask

	task automatic t_load();
		req(OP_MODE_LOAD, 1'b0, 9'h020, 8'h00, 1'b0, 32'h0, 4'h0);
		req(OP_SPECIAL_LOAD, 1'b1, 9'h0, 8'h00, 1'b0, 32'hff, 4'h0);
		rdchk(1'b1, 9'h105, 8'h03, 1'b0, 32'h00c0_ffee);
		end_test("register_load");
	endtask

	task automatic t_ref();
		r0 = refs;
		repeat (830) @(posedge clk);
		chk("refresh seen", 32'h1, {31'h0, refs != r0});
		end_test("refresh");
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		#400000;
		err_count++;
		close_out();
	end

	initial begin
		err_count = 0;
		n_compared = 0;
		{rst_b, slow, valid, bank, ap} = 5'h00;
		op = OP_READ;
		row = '0;
		col = '0;
		wdata = '0;
		wmask = '0;
		do_reset(1'b0);
		t_rw();
		t_miss();
		t_blk();
		t_ap();
		t_load();
		t_ref();
		do_reset(1'b1);
		t_rw();
		t_miss();
		t_blk();
		t_ref();
		close_out();
	end
endmodule
